// File: rtl/plrc_map.svh
`ifndef PLRC_MAP_SVH
`define PLRC_MAP_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define PLRC_OFS_SOFT_RESET_AND_CALIBRATE     8'h88
`define PLRC_OFS_FAST_LOCK_CONTROL            8'h89
`define PLRC_OFS_SIGNAL_LOSS_MONITOR_ENABLE_A 8'h8a
`define PLRC_OFS_SIGNAL_LOSS_MONITOR_ENABLE_B 8'h8b

// ***************************************************************
// Field positions
// ***************************************************************
`define PLRC_BIT_SOFT_RESET          7
`define PLRC_BIT_CALIBRATION_TRIGGER 6
`define PLRC_BIT_FAST_LOCK_ENABLE    0
`define PLRC_BIT_IN1_EN_A            0
`define PLRC_BIT_IN2_EN_A            1
`define PLRC_BIT_IN1_EN_B            4
`define PLRC_BIT_IN2_EN_B            5

// ***************************************************************
// Reset values
// ***************************************************************
`define PLRC_RST_SOFT_RESET_AND_CALIBRATE     8'h00
`define PLRC_RST_FAST_LOCK_CONTROL            8'h00
`define PLRC_RST_SIGNAL_LOSS_MONITOR_ENABLE_A 8'h00
`define PLRC_RST_SIGNAL_LOSS_MONITOR_ENABLE_B 8'hff

// ***************************************************************
// Timing
// ***************************************************************
`define PLRC_CLK_HZ          20000000
`define PLRC_SOFT_RESET_US   10000
`define PLRC_SOFT_RESET_CYC  ((`PLRC_CLK_HZ / 1000000) * `PLRC_SOFT_RESET_US)
`define PLRC_CAL_CYC_DEFAULT 256
`define PLRC_CNT_W           24

`endif

// File: rtl/plrc_pkg.sv
package plrc_pkg;

  typedef enum logic [1:0]
  {
    PLRC_MON_OFF      = 2'b00,
    PLRC_MON_RESERVED = 2'b01,
    PLRC_MON_SLOW     = 2'b10,
    PLRC_MON_FULL     = 2'b11
  } plrc_mon_t;

  typedef enum logic [1:0]
  {
    PLRC_IDLE,
    PLRC_SOFT_RESET,
    PLRC_CALIBRATE
  } plrc_state_t;

endpackage

// File: rtl/plrc_mon_decode.sv
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// Per-input monitor mode decode
// ***************************************************************
module plrc_mon_decode
(
  input  wire logic [1:0] mon_enable_a,
  input  wire logic [1:0] mon_enable_b,
  output logic      [1:0] slow_signal_loss_monitor,
  output logic      [1:0] signal_loss_monitor
);

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_in
      plrc_pkg::plrc_mon_t mode;
      // Lower-addressed register holds the field MSB
      assign mode = plrc_pkg::plrc_mon_t'({mon_enable_a[i], mon_enable_b[i]});
      // Reserved code 01 treated as disabled
      assign slow_signal_loss_monitor[i] = (mode == plrc_pkg::PLRC_MON_SLOW);
      assign signal_loss_monitor[i]      = (mode == plrc_pkg::PLRC_MON_FULL);
    end
  endgenerate

endmodule

`default_nettype wire

// File: rtl/plrc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "plrc_map.svh"

// Behaviour
// - Writing 1 to bit 7 of the reset register resets all internal logic like the reset pin; 0 is normal running.
// - While that soft reset is in effect the clock outputs are held disabled.
// - Writing 1 to bit 6 starts self-calibration, and the bit clears itself.
// - Calibration completion shows as the loss-of-lock alarm going low.
// - A shift above 500 ppm of the input clock may start calibration on its own.
// - Fast-lock enable in bit 0, reset 0x00, asks the loop for dynamic bandwidth during acquisition.
// - Each input monitor enable is two bits split over two registers, bits 0/4 for input 1 and 1/5 for input 2.
// - Codes are 00 off, 01 reserved, 10 slow monitoring, 11 full monitoring.
// - Slow monitoring detects loss later and less sensitively than full monitoring.
// - The second monitor enable register resets to 0xff.
// - The loss-of-lock status reads 0 when locked and 1 when unlocked; the alarm here also reads 1 while locked until a calibration has completed.
module plrc_top
#(
  parameter int unsigned SOFT_RESET_CYC = `PLRC_SOFT_RESET_CYC,
  parameter int unsigned CAL_CYC        = `PLRC_CAL_CYC_DEFAULT
)
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       pll_locked,
  input  wire logic       freq_shift,
  output logic            clock_output_enable,
  output logic            pll_core_reset,
  output logic            calibrating,
  output logic            loss_of_lock_alarm,
  output logic            fast_lock_enable,
  output logic      [1:0] slow_signal_loss_monitor,
  output logic      [1:0] signal_loss_monitor
);

  // ***************************************************************
  // Reset release and pin synchronisers
  // ***************************************************************
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [1:0] lock_sync;
  logic [1:0] shift_sync;
  logic       shift_prev;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_sync  <= 2'b00;
      shift_sync <= 2'b00;
      shift_prev <= 1'b0;
    end
    else
    begin
      lock_sync  <= {lock_sync[0], pll_locked};
      shift_sync <= {shift_sync[0], freq_shift};
      shift_prev <= shift_sync[1];
    end
  end

  // ***************************************************************
  // Registers and sequencer
  // ***************************************************************
  plrc_pkg::plrc_state_t state;
  plrc_pkg::plrc_state_t next_state;
  logic [`PLRC_CNT_W-1:0] cnt;
  logic [`PLRC_CNT_W-1:0] next_cnt;
  logic [7:0] fast_lock_control;
  logic [7:0] next_fast_lock_control;
  logic [1:0] mon_a;
  logic [1:0] next_mon_a;
  logic [1:0] mon_b;
  logic [1:0] next_mon_b;
  logic       cal_done;
  logic       next_cal_done;
  logic       wr_ctl;
  logic       auto_cal;

  assign wr_ctl   = reg_wr && (reg_addr == `PLRC_OFS_SOFT_RESET_AND_CALIBRATE);
  // Input shift above threshold flagged by the front end
  assign auto_cal = shift_sync[1] && !shift_prev;

  always_comb
  begin
    next_state             = state;
    next_cnt               = cnt;
    next_fast_lock_control = fast_lock_control;
    next_mon_a             = mon_a;
    next_mon_b             = mon_b;
    next_cal_done          = cal_done;
    case (state)
      plrc_pkg::PLRC_IDLE:
      begin
        if (reg_wr && reg_addr == `PLRC_OFS_FAST_LOCK_CONTROL)
          next_fast_lock_control = reg_wdata;
        if (reg_wr && reg_addr == `PLRC_OFS_SIGNAL_LOSS_MONITOR_ENABLE_A)
          next_mon_a = {reg_wdata[`PLRC_BIT_IN2_EN_A], reg_wdata[`PLRC_BIT_IN1_EN_A]};
        if (reg_wr && reg_addr == `PLRC_OFS_SIGNAL_LOSS_MONITOR_ENABLE_B)
          next_mon_b = {reg_wdata[`PLRC_BIT_IN2_EN_B], reg_wdata[`PLRC_BIT_IN1_EN_B]};
        if (wr_ctl && reg_wdata[`PLRC_BIT_SOFT_RESET])
        begin
          next_state    = plrc_pkg::PLRC_SOFT_RESET;
          next_cnt      = '0;
          // Alarm must not dip low on the entry edge
          next_cal_done = 1'b0;
        end
        else if ((wr_ctl && reg_wdata[`PLRC_BIT_CALIBRATION_TRIGGER]) || auto_cal)
        begin
          next_state    = plrc_pkg::PLRC_CALIBRATE;
          next_cnt      = '0;
          next_cal_done = 1'b0;
        end
      end
      plrc_pkg::PLRC_SOFT_RESET:
      begin
        // Same as the pin: every register back to default
        next_fast_lock_control = `PLRC_RST_FAST_LOCK_CONTROL;
        next_mon_a             = 2'b00;
        next_mon_b             = 2'b11;
        next_cal_done          = 1'b0;
        next_cnt               = cnt + 1'b1;
        // Port is ignored for the whole hold, host must wait anyway
        if (cnt >= `PLRC_CNT_W'(SOFT_RESET_CYC - 1))
          next_state = plrc_pkg::PLRC_IDLE;
      end
      plrc_pkg::PLRC_CALIBRATE:
      begin
        if (cnt < `PLRC_CNT_W'(CAL_CYC))
          next_cnt = cnt + 1'b1;
        // Complete when settled and the loop reports lock
        if (cnt >= `PLRC_CNT_W'(CAL_CYC) && lock_sync[1])
        begin
          next_state    = plrc_pkg::PLRC_IDLE;
          next_cal_done = 1'b1;
        end
        if (wr_ctl && reg_wdata[`PLRC_BIT_SOFT_RESET])
        begin
          next_state    = plrc_pkg::PLRC_SOFT_RESET;
          next_cnt      = '0;
          // Soft reset wins over a completion in the same cycle
          next_cal_done = 1'b0;
        end
      end
      default:
        next_state = plrc_pkg::PLRC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state             <= plrc_pkg::PLRC_IDLE;
      cnt               <= '0;
      fast_lock_control <= `PLRC_RST_FAST_LOCK_CONTROL;
      mon_a             <= 2'b00;
      mon_b             <= 2'b11;
      cal_done          <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      cnt               <= next_cnt;
      fast_lock_control <= next_fast_lock_control;
      mon_a             <= next_mon_a;
      mon_b             <= next_mon_b;
      cal_done          <= next_cal_done;
    end
  end

  // ***************************************************************
  // Outputs and read back
  // ***************************************************************
  logic [7:0] next_rdata;
  logic [7:0] next_reg_rdata;
  logic       next_clock_output_enable;
  logic       next_pll_core_reset;
  logic       next_calibrating;
  logic       next_loss_of_lock_alarm;
  logic       next_fast_lock_enable;

  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `PLRC_OFS_SOFT_RESET_AND_CALIBRATE:
        // Trigger reads 1 only while the sequence runs
        next_rdata = {1'b0, state == plrc_pkg::PLRC_CALIBRATE, 6'h00};
      `PLRC_OFS_FAST_LOCK_CONTROL:
        next_rdata = fast_lock_control;
      `PLRC_OFS_SIGNAL_LOSS_MONITOR_ENABLE_A:
        next_rdata = {6'h00, mon_a};
      `PLRC_OFS_SIGNAL_LOSS_MONITOR_ENABLE_B:
        // Reserved bits keep the all-ones default
        next_rdata = {2'b11, mon_b, 4'hf};
      default:
        next_rdata = 8'h00;
    endcase
    next_reg_rdata = reg_rdata;
    if (reg_rd && state != plrc_pkg::PLRC_SOFT_RESET)
      next_reg_rdata = next_rdata;
    next_clock_output_enable = (next_state == plrc_pkg::PLRC_IDLE) && next_cal_done;
    next_pll_core_reset      = (next_state == plrc_pkg::PLRC_SOFT_RESET);
    next_calibrating         = (next_state == plrc_pkg::PLRC_CALIBRATE);
    // High while unlocked or uncalibrated, low on completion
    next_loss_of_lock_alarm  = !(next_cal_done && lock_sync[1]);
    next_fast_lock_enable    = next_fast_lock_control[`PLRC_BIT_FAST_LOCK_ENABLE];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata           <= 8'h00;
      clock_output_enable <= 1'b0;
      pll_core_reset      <= 1'b1;
      calibrating         <= 1'b0;
      loss_of_lock_alarm  <= 1'b1;
      fast_lock_enable    <= 1'b0;
    end
    else
    begin
      reg_rdata           <= next_reg_rdata;
      clock_output_enable <= next_clock_output_enable;
      pll_core_reset      <= next_pll_core_reset;
      calibrating         <= next_calibrating;
      loss_of_lock_alarm  <= next_loss_of_lock_alarm;
      fast_lock_enable    <= next_fast_lock_enable;
    end
  end

  plrc_mon_decode u_mon
  (
    .mon_enable_a             (mon_a),
    .mon_enable_b             (mon_b),
    .slow_signal_loss_monitor (slow_signal_loss_monitor),
    .signal_loss_monitor      (signal_loss_monitor)
  );

endmodule

`default_nettype wire

// File: sim/plrc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module plrc_monitor
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       pll_locked,
  input wire logic       clock_output_enable,
  input wire logic       pll_core_reset,
  input wire logic       calibrating,
  input wire logic       loss_of_lock_alarm,
  input wire logic       fast_lock_enable,
  input wire logic [1:0] slow_signal_loss_monitor,
  input wire logic [1:0] signal_loss_monitor
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire wr_88 = reg_wr && reg_addr == 8'h88 && !pll_core_reset;
  chk_cal_no_out: assert property (calibrating |-> !clock_output_enable)
    else $error("clock outputs on during calibration");
  chk_reset_no_out: assert property (pll_core_reset |-> !clock_output_enable)
    else $error("clock outputs on during reset");
  chk_reset_alarm_high: assert property (pll_core_reset |-> loss_of_lock_alarm)
    else $error("alarm low during reset");
  chk_cal_alarm_high: assert property (calibrating |-> loss_of_lock_alarm)
    else $error("alarm low while calibrating");
  chk_done_alarm_low: assert property ($fell(calibrating) && !pll_core_reset |-> !loss_of_lock_alarm)
    else $error("alarm still high after calibration");
  chk_cal_start: assert property (wr_88 && reg_wdata[7:6] == 2'h1 && !calibrating |=> calibrating)
    else $error("calibration did not start");
  chk_soft_rst: assert property (wr_88 && reg_wdata[7] |=> pll_core_reset [*8])
    else $error("soft reset not held");
  chk_fast_lock: assert property (reg_wr && reg_addr == 8'h89 && !pll_core_reset && !calibrating
    |-> ##2 fast_lock_enable == $past(reg_wdata[0], 2)) else $error("fast lock output wrong");
  chk_unmapped_zero: assert property (reg_rd && !pll_core_reset && (reg_addr < 8'h88 || reg_addr > 8'h8b)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_mon_exclusive: assert property ((signal_loss_monitor & slow_signal_loss_monitor) == 2'h0)
    else $error("both monitor modes on");
  chk_unlock_alarm: assert property (!pll_locked [*4] |-> loss_of_lock_alarm)
    else $error("alarm low while unlocked");
endmodule
`default_nettype wire

// File: sim/plrc_pll_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Loop model: relocks a few cycles after reset or a forced loss
// ********
module plrc_pll_model
#(
  parameter int LOCK_CYC = 4
)
(
  input wire logic mclk,
  input wire logic pll_core_reset,
  input wire logic lose,
  output logic     pll_locked
);
  int cnt = 0;
  always_ff @(posedge mclk)
    if (pll_core_reset || lose)
      cnt <= 0;
    else if (cnt < LOCK_CYC)
      cnt <= cnt + 1;
  assign pll_locked = (cnt == LOCK_CYC);
endmodule
`default_nettype wire

// File: sim/pll_reset_calibration_los_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench top
// ********
module pll_reset_calibration_los_control_bench;
  logic       mclk, rst_b, reg_wr, reg_rd, freq_shift, lose, pll_locked;
  logic       oe, core_rst, cal, alarm, fast;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] slow, full, c1, c2;
  logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
  int         err_count = 0;
  int         n_compared = 0;
  plrc_top #(.SOFT_RESET_CYC(16), .CAL_CYC(8)) plrc_top_inst (.mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .pll_locked, .freq_shift, .clock_output_enable(oe), .pll_core_reset(core_rst),
    .calibrating(cal), .loss_of_lock_alarm(alarm), .fast_lock_enable(fast), .slow_signal_loss_monitor(slow),
    .signal_loss_monitor(full));
  plrc_pll_model plrc_pll_model_inst (.mclk, .pll_core_reset(core_rst), .lose, .pll_locked);
  initial
  begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 0;
    @(negedge mclk);
    chk(reg_rdata, exp);
  endtask
  // Calibration ends within CAL_CYC plus sync, so 100 is generous
  task automatic wait_cal(input logic v);
    for (int k = 0; k < 100 && cal !== v; k++) @(negedge mclk);
    if (cal !== v)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  initial
  begin
    {rst_b, reg_wr, reg_rd, freq_shift, lose, reg_addr, reg_wdata} = '0;
    repeat (5) @(negedge mclk);
    rst_b = 1;
    repeat (3) @(negedge mclk);
    chk(8'({oe, alarm, full, slow}), 8'h10);
    rd(8'h8b, 8'hff);
    rd(8'h89, 8'h00);
    rd(8'h8a, 8'h00);
    rd(8'h8c, 8'h00);
    wr(8'h88, 8'h40);
    chk(8'({cal, oe, alarm}), 8'h05);
    wait_cal(0);
    chk(8'({oe, alarm}), 8'h02);
    rd(8'h88, 8'h00);
    wr(8'h89, 8'h01);
    @(negedge mclk);
    chk(8'(fast), 8'h01);
    rd(8'h89, 8'h01);
    wr(8'h89, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      c1 = codes[i];
      c2 = codes[(i + 1) % 3];
      wr(8'h8a, {6'h00, c2[1], c1[1]});
      wr(8'h8b, {2'h3, c2[0], c1[0], 4'hf});
      chk(8'({full, slow}), 8'({c2 == 2'h3, c1 == 2'h3, c2 == 2'h2, c1 == 2'h2}));
    end
    wr(8'h88, 8'h40);
    wr(8'h89, 8'h01);
    wait_cal(0);
    rd(8'h89, 8'h00);
    lose = 1;
    repeat (6) @(negedge mclk);
    chk(8'(alarm), 8'h01);
    lose = 0;
    repeat (10) @(negedge mclk);
    chk(8'(alarm), 8'h00);
    freq_shift = 1;
    wait_cal(1);
    freq_shift = 0;
    wait_cal(0);
    chk(8'({oe, alarm}), 8'h02);
    wr(8'h8a, 8'h03);
    wr(8'h88, 8'h40);
    wr(8'h88, 8'h80);
    chk(8'({core_rst, cal, oe}), 8'h04);
    repeat (20) @(negedge mclk);
    rd(8'h8a, 8'h00);
    rd(8'h8b, 8'hff);
    chk(8'({oe, alarm}), 8'h01);
    wr(8'h88, 8'h40);
    wait_cal(0);
    chk(8'({oe, alarm}), 8'h02);
    // Soft reset from a calibrated idle: alarm must rise with the reset
    wr(8'h88, 8'h80);
    chk(8'({core_rst, oe, alarm}), 8'h05);
    print_verdict();
  end
endmodule
bind plrc_top plrc_monitor plrc_monitor_inst (.mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .pll_locked, .clock_output_enable, .pll_core_reset, .calibrating, .loss_of_lock_alarm, .fast_lock_enable,
  .slow_signal_loss_monitor, .signal_loss_monitor);
`default_nettype wire
